/* File: hafr_pkg.sv */
/*
  Shared constants and types for the host response framer: frame codes,
  byte offsets, status codes, lengths, request and state carriers.
  Assumes a byte-wide serial transmitter downstream and one clock domain.
*/
package hafr_pkg;

  // ==========================================================
  // Frame codes
  localparam logic [7:0] DELIM = 8'h7E;
  localparam logic [7:0] TYPE_RX = 8'h80;
  localparam logic [7:0] TYPE_RMT = 8'h87;
  localparam logic [7:0] TYPE_LOC = 8'h88;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================
  // Byte offsets within a frame
  localparam logic [4:0] OFF_LEN_HI = 5'h01;
  localparam logic [4:0] OFF_LEN_LO = 5'h02;
  localparam logic [4:0] OFF_TYPE = 5'h03;
  localparam logic [4:0] OFF_FID = 5'h04;
  localparam logic [4:0] RX_ADDR = 5'h04;
  localparam logic [4:0] RX_IP = 5'h08;
  localparam logic [4:0] RX_MARGIN = 5'h0C;
  localparam logic [4:0] RX_OPT = 5'h0D;
  localparam logic [4:0] RX_LAST = 5'h0D;
  localparam logic [4:0] RMT_ADDR = 5'h05;
  localparam logic [4:0] RMT_IP = 5'h09;
  localparam logic [4:0] RMT_CMD_HI = 5'h0D;
  localparam logic [4:0] RMT_CMD_LO = 5'h0E;
  localparam logic [4:0] RMT_STAT = 5'h0F;
  localparam logic [4:0] RMT_LAST = 5'h0F;
  localparam logic [4:0] LOC_CMD_HI = 5'h05;
  localparam logic [4:0] LOC_CMD_LO = 5'h06;
  localparam logic [4:0] LOC_STAT = 5'h07;
  localparam logic [4:0] LOC_LAST = 5'h07;

  // ==========================================================
  // Lengths: fixed bytes from frame type to last header byte, and the payload maximum
  localparam logic [15:0] RX_FIXED = 16'h000B;
  localparam logic [15:0] RMT_FIXED = 16'h000D;
  localparam logic [15:0] LOC_FIXED = 16'h0005;
  localparam logic [10:0] PAY_MAX = 11'h570;

  // ==========================================================
  // Status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ERR = 8'h01;
  localparam logic [7:0] ST_BADCMD = 8'h02;
  localparam logic [7:0] ST_BADPARAM = 8'h03;
  localparam logic [7:0] ST_TXFAIL = 8'h04;

  // ==========================================================
  // Buffer shape
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    KIND_RX = 2'h0,
    KIND_RMT = 2'h1,
    KIND_LOC = 2'h2
  } hafr_kind_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HEAD = 4'h2,
    ST_BODY = 4'h4,
    ST_SUM = 4'h8
  } hafr_state_e;

  typedef struct packed {
    hafr_kind_e kind;
    logic [7:0] frame_id;
    logic [31:0] ip;
    logic [7:0] margin;
    logic [7:0] options;
    logic [15:0] cmd;
    logic [7:0] status;
    logic has_param;
    logic [10:0] plen;
  } hafr_req_s;

  typedef struct packed {
    hafr_state_e state;
    logic [4:0] idx;
    logic [10:0] remain;
    logic [15:0] len;
    logic [7:0] sum;
    logic [7:0] tx_data;
    logic tx_valid;
    logic req_ready;
    hafr_req_s req;
  } hafr_st_s;

endpackage

/* File: hafr_fifo.sv */
/*
  Byte FIFO between the payload source and the framer.
  Assumes one clock and a reset already synchronised by the caller.
*/
`timescale 1ns/1ps
module hafr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } hafr_fifo_st_s;

  hafr_fifo_st_s st_reg;
  hafr_fifo_st_s st_next;
  logic push;
  logic pop;

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    push = in_valid_i && st_reg.rdy;
    pop = out_ready_i && (st_reg.cnt != '0);
    if (push) begin
      st_next.mem[st_reg.wp] = in_data_i;
      st_next.wp = (st_reg.wp == AW'(D - 1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(D - 1)) ? '0 : st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    // Registered so the source sees back-pressure from a flop
    st_next.rdy = (st_next.cnt != (AW + 1)'(D));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready_o = st_reg.rdy;
  assign out_valid_o = (st_reg.cnt != '0);
  assign out_data_o = st_reg.mem[st_reg.rp];

endmodule

/* File: hafr_framer.sv */
/*
  Host response framer: serialises receive-packet, remote response and
  local response frames into a byte stream toward the host serial port.
  Assumes the request fields are stable while req_valid_i is high and the
  payload bytes of a frame arrive in order on the payload port.
*/
// Function
// - A legacy receive-packet frame carries type code 0x80 at byte 3, kept only for old software.
// - The 64-bit address holds the 32-bit IP address in its low four bytes with zeros above.
// - The receive-packet frame puts the link margin at byte 12 and an undefined options byte at 13.
// - The receive-packet payload starts at byte 14 and is at most 1392 bytes.
// - A response to a remote command produces a frame with type code 0x87 toward the host.
// - The remote response holds the responder address at bytes 5-12 and the command at 13-14, high first.
// - The remote status byte at 15 is 0 ok, 1 error, 2 bad command, 3 bad parameter, 4 send failure.
// - The remote response carries a parameter value only when it answers a query.
// - Each local command from the host is answered by a frame with type code 0x88.
// - Some commands, such as a scan, are answered by several frames in a row.
// - The local response echoes the two command characters at bytes 5 and 6.
// - The local status byte is 0 ok, 1 error, 2 bad command, 3 bad parameter.
// - The local response carries a parameter value only when the host reads a setting.
`timescale 1ns/1ps
module hafr_framer (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire hafr_pkg::hafr_req_s req_i,
  output logic req_ready_o,
  input wire logic pay_valid_i,
  input wire logic [7:0] pay_data_i,
  output logic pay_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // Payload buffer
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;

  hafr_fifo #(
    .W(hafr_pkg::BYTE_W),
    .D(hafr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(pay_valid_i),
    .in_data_i(pay_data_i),
    .in_ready_o(pay_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  // ==========================================================
  // Header bytes
  function automatic logic [7:0] hdr_byte(input hafr_pkg::hafr_st_s s, input logic [4:0] i);
    logic [7:0] b;
    b = hafr_pkg::ZERO_BYTE;
    if (i == 5'h00) begin
      b = hafr_pkg::DELIM;
    end else if (i == hafr_pkg::OFF_LEN_HI) begin
      b = s.len[15:8];
    end else if (i == hafr_pkg::OFF_LEN_LO) begin
      b = s.len[7:0];
    end else begin
      case (s.req.kind)
        hafr_pkg::KIND_RX: begin
          if (i == hafr_pkg::OFF_TYPE) begin
            b = hafr_pkg::TYPE_RX;
          end else if (i >= hafr_pkg::RX_IP && i < hafr_pkg::RX_MARGIN) begin
            b = s.req.ip[8'(hafr_pkg::RX_MARGIN - 5'h01 - i) * 8 +: 8];
          end else if (i == hafr_pkg::RX_MARGIN) begin
            b = s.req.margin;
          end else if (i == hafr_pkg::RX_OPT) begin
            b = s.req.options;
          end
        end
        hafr_pkg::KIND_RMT: begin
          if (i == hafr_pkg::OFF_TYPE) begin
            b = hafr_pkg::TYPE_RMT;
          end else if (i == hafr_pkg::OFF_FID) begin
            b = s.req.frame_id;
          end else if (i >= hafr_pkg::RMT_IP && i < hafr_pkg::RMT_CMD_HI) begin
            b = s.req.ip[8'(hafr_pkg::RMT_CMD_HI - 5'h01 - i) * 8 +: 8];
          end else if (i == hafr_pkg::RMT_CMD_HI) begin
            b = s.req.cmd[15:8];
          end else if (i == hafr_pkg::RMT_CMD_LO) begin
            b = s.req.cmd[7:0];
          end else if (i == hafr_pkg::RMT_STAT) begin
            b = s.req.status;
          end
        end
        hafr_pkg::KIND_LOC: begin
          if (i == hafr_pkg::OFF_TYPE) begin
            b = hafr_pkg::TYPE_LOC;
          end else if (i == hafr_pkg::OFF_FID) begin
            b = s.req.frame_id;
          end else if (i == hafr_pkg::LOC_CMD_HI) begin
            b = s.req.cmd[15:8];
          end else if (i == hafr_pkg::LOC_CMD_LO) begin
            b = s.req.cmd[7:0];
          end else if (i == hafr_pkg::LOC_STAT) begin
            b = s.req.status;
          end
        end
        default: begin
          b = hafr_pkg::ZERO_BYTE;
        end
      endcase
    end
    return b;
  endfunction

  // ==========================================================
  // Framing state machine
  hafr_pkg::hafr_st_s st_reg;
  hafr_pkg::hafr_st_s st_next;
  logic slot_free;
  logic accept;
  logic [4:0] last_idx;
  logic [4:0] nidx;
  logic [7:0] nbyte;

  always_comb begin
    st_next = st_reg;
    slot_free = !st_reg.tx_valid || tx_ready_i;
    accept = req_valid_i && st_reg.req_ready;
    fifo_pop = 1'b0;
    nidx = st_reg.idx + 5'h01;
    case (st_reg.req.kind)
      hafr_pkg::KIND_RMT: last_idx = hafr_pkg::RMT_LAST;
      hafr_pkg::KIND_LOC: last_idx = hafr_pkg::LOC_LAST;
      default: last_idx = hafr_pkg::RX_LAST;
    endcase
    nbyte = hdr_byte(st_reg, nidx);
    case (st_reg.state)
      hafr_pkg::ST_IDLE: begin
        // Back-to-back requests allowed, so multi-frame answers flow
        if (accept) begin
          st_next.req = req_i;
          if (req_i.kind != hafr_pkg::KIND_RX && !req_i.has_param) begin
            st_next.req.plen = 11'h000;
          end
          // Clamp after the forced zero, so a set response never waits on payload
          if (st_next.req.plen > hafr_pkg::PAY_MAX) begin
            st_next.req.plen = hafr_pkg::PAY_MAX;
          end
          // Out-of-range codes would confuse the host; report plain error
          if (req_i.kind == hafr_pkg::KIND_RMT && req_i.status > hafr_pkg::ST_TXFAIL) begin
            st_next.req.status = hafr_pkg::ST_ERR;
          end
          if (req_i.kind == hafr_pkg::KIND_LOC && req_i.status > hafr_pkg::ST_BADPARAM) begin
            st_next.req.status = hafr_pkg::ST_ERR;
          end
          case (req_i.kind)
            hafr_pkg::KIND_RMT: st_next.len = hafr_pkg::RMT_FIXED;
            hafr_pkg::KIND_LOC: st_next.len = hafr_pkg::LOC_FIXED;
            default: st_next.len = hafr_pkg::RX_FIXED;
          endcase
          st_next.len = st_next.len + 16'(st_next.req.plen);
          st_next.remain = st_next.req.plen;
          st_next.sum = 8'h00;
          st_next.idx = 5'h00;
          st_next.tx_data = hafr_pkg::DELIM;
          st_next.tx_valid = 1'b1;
          st_next.state = hafr_pkg::ST_HEAD;
        end
      end
      hafr_pkg::ST_HEAD: begin
        if (tx_ready_i) begin
          if (st_reg.idx == last_idx) begin
            st_next.tx_valid = 1'b0;
            st_next.state = hafr_pkg::ST_BODY;
          end else begin
            st_next.idx = nidx;
            st_next.tx_data = nbyte;
            if (nidx >= hafr_pkg::OFF_TYPE) begin
              st_next.sum = st_reg.sum + nbyte;
            end
          end
        end
      end
      hafr_pkg::ST_BODY: begin
        if (slot_free) begin
          if (st_reg.remain == 11'h000) begin
            st_next.tx_data = ~st_reg.sum;
            st_next.tx_valid = 1'b1;
            st_next.state = hafr_pkg::ST_SUM;
          end else if (fifo_valid) begin
            fifo_pop = 1'b1;
            st_next.tx_data = fifo_data;
            st_next.tx_valid = 1'b1;
            st_next.sum = st_reg.sum + fifo_data;
            st_next.remain = st_reg.remain - 11'h001;
          end else begin
            st_next.tx_valid = 1'b0;
          end
        end
      end
      hafr_pkg::ST_SUM: begin
        if (tx_ready_i) begin
          st_next.tx_valid = 1'b0;
          st_next.state = hafr_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.tx_valid = 1'b0;
        st_next.state = hafr_pkg::ST_IDLE;
      end
    endcase
    st_next.req_ready = (st_next.state == hafr_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= hafr_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_ready_o = st_reg.req_ready;
  assign tx_data_o = st_reg.tx_data;
  assign tx_valid_o = st_reg.tx_valid;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  logic in_head;
  assign in_head = (st_reg.state == hafr_pkg::ST_HEAD);

  sequence s_accept;
    req_valid_i && req_ready_o;
  endsequence

  sequence s_delim;
    tx_valid_o && tx_data_o == 8'h7E;
  endsequence

  a_delim_first: assert property (
    s_accept |=> s_delim ##0 (in_head && st_reg.idx == 5'h00))
    else $error("Frame did not open with delimiter");

  a_len_bytes: assert property (
    in_head && st_reg.idx == 5'h01 && tx_ready_i |=> tx_data_o == st_reg.len[7:0])
    else $error("Length low byte wrong");

  a_rx_type: assert property (
    in_head && st_reg.idx == 5'h03 && st_reg.req.kind == hafr_pkg::KIND_RX
      |-> tx_data_o == 8'h80)
    else $error("Receive frame type wrong");

  a_addr_upper: assert property (
    in_head && st_reg.req.kind == hafr_pkg::KIND_RMT && st_reg.idx >= 5'h05
      && st_reg.idx <= 5'h08 |-> tx_data_o == 8'h00)
    else $error("Upper address byte not zero");

  a_margin_byte: assert property (
    in_head && st_reg.idx == 5'h0C && st_reg.req.kind == hafr_pkg::KIND_RX
      |-> tx_data_o == st_reg.req.margin)
    else $error("Link margin misplaced");

  a_payload_cap: assert property (
    st_reg.remain <= 11'd1392)
    else $error("Payload exceeds maximum");

  a_payload_clamp: assert property (
    s_accept ##0 (req_i.kind == hafr_pkg::KIND_RX && req_i.plen > 11'd1392)
      |=> st_reg.remain == 11'd1392 && st_reg.len == 16'd1403)
    else $error("Oversized payload not clamped");

  a_rmt_type: assert property (
    in_head && st_reg.idx == 5'h03 && st_reg.req.kind == hafr_pkg::KIND_RMT
      |-> tx_data_o == 8'h87)
    else $error("Remote frame type wrong");

  a_rmt_cmd: assert property (
    in_head && st_reg.idx == 5'h0D && st_reg.req.kind == hafr_pkg::KIND_RMT && tx_ready_i
      |-> tx_data_o == st_reg.req.cmd[15:8] ##1 tx_data_o == st_reg.req.cmd[7:0])
    else $error("Remote command bytes wrong");

  a_rmt_status: assert property (
    in_head && st_reg.idx == 5'h0F && st_reg.req.kind == hafr_pkg::KIND_RMT
      |-> tx_data_o <= 8'h04)
    else $error("Remote status out of range");

  a_loc_status: assert property (
    in_head && st_reg.idx == 5'h07 && st_reg.req.kind == hafr_pkg::KIND_LOC
      |-> tx_data_o <= 8'h03)
    else $error("Local status out of range");

  a_no_param: assert property (
    s_accept ##0 (req_i.kind == hafr_pkg::KIND_LOC && !req_i.has_param)
      |=> st_reg.len == 16'h0005)
    else $error("Set response carries a value");

  a_sum_last: assert property (
    st_reg.state == hafr_pkg::ST_SUM && tx_valid_o && tx_ready_i
      |-> (8'(st_reg.sum + tx_data_o) == 8'hFF) ##1 req_ready_o)
    else $error("Checksum wrong");

endmodule

/* File: hafr_host_model.sv */
/*
  Host side of the serial link: takes framed bytes from the framer and
  keeps every transferred byte in order for the bench to inspect.
  Assumes one clock; ready is moved on the falling edge only.
*/
`timescale 1ns/1ps
module hafr_host_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  // ==========================================================
  // Capture
  // Slow mode takes one byte in three, so stalls land mid-frame
  logic [7:0] got_q[$];
  logic [1:0] phase = 2'h0;
  logic rdy = 1'b1;

  assign tx_ready_o = rdy;

  always @(negedge clk_i) begin
    phase = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    rdy = !stall_i || (phase == 2'h0);
    // Byte counts as taken at the coming rising edge
    if (tx_valid_i && rdy) got_q.push_back(tx_data_i);
  end
endmodule

/* File: tb_top.sv */
/*
  Self-checking bench for the host response framer: builds each expected
  frame from the field values and compares it with what the host saw.
  Assumes the framer, its FIFO and the host model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  // ==========================================================
  // Signals
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  hafr_pkg::hafr_req_s req_i = '0;
  logic req_ready_o;
  logic pay_valid_i = 1'b0;
  logic [7:0] pay_data_i = 8'h00;
  logic pay_ready_o;
  logic [7:0] tx_data_o;
  logic tx_valid_o;
  logic tx_ready_i;
  logic stall = 1'b0;
  logic feed_on = 1'b1;
  logic took = 1'b0;
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] pay_q[$];
  logic [7:0] exp_q[$];

  always #2.5 ref_clk_i = ~ref_clk_i;

  hafr_framer DUT (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .pay_valid_i(pay_valid_i),
    .pay_data_i(pay_data_i), .pay_ready_o(pay_ready_o), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i)
  );

  hafr_host_model HOST (
    .clk_i(ref_clk_i), .stall_i(stall), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i)
  );

  // ==========================================================
  // Payload feeder
  // Idle data is inverted so a stale byte never passes for a fresh one
  always @(negedge ref_clk_i) begin
    if (took) void'(pay_q.pop_front());
    pay_valid_i = feed_on && (pay_q.size() > 0);
    pay_data_i = pay_valid_i ? pay_q[0] : ~pay_data_i;
    took = pay_valid_i && pay_ready_o;
  end

  // ==========================================================
  // Closing
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang();
    err_total++;
    $display("CHECK FAILED t=%0t wait limit reached", $time);
    stop_test();
  endtask

  // ==========================================================
  // Helpers
  function automatic hafr_pkg::hafr_req_s mk(input hafr_pkg::hafr_kind_e k,
      input logic [7:0] fid, input logic [15:0] cmd, input logic [7:0] st,
      input logic hp, input logic [10:0] pl);
    mk = '{kind: k, frame_id: fid, ip: 32'hC0A80067, margin: 8'h2E, options: 8'h00,
           cmd: cmd, status: st, has_param: hp, plen: pl};
  endfunction

  task automatic send_req(input hafr_pkg::hafr_req_s r);
    int i;
    @(negedge ref_clk_i);
    req_i = r;
    req_valid_i = 1'b1;
    for (i = 0; i < 4000 && req_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 4000) hang();
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
  endtask

  // Expected bytes come from the field values, never from the framer
  task automatic frame(input hafr_pkg::hafr_req_s r, input logic [7:0] pl[$],
      input bit feed = 1'b1);
    logic [7:0] b[$];
    logic [7:0] sum;
    logic [7:0] st;
    logic [15:0] n;
    sum = 8'h00;
    st = r.status;
    if (r.kind == hafr_pkg::KIND_RMT && st > hafr_pkg::ST_TXFAIL) st = hafr_pkg::ST_ERR;
    if (r.kind == hafr_pkg::KIND_LOC && st > hafr_pkg::ST_BADPARAM) st = hafr_pkg::ST_ERR;
    case (r.kind)
      hafr_pkg::KIND_RX: b = {hafr_pkg::TYPE_RX, 8'h00, 8'h00, 8'h00, 8'h00};
      hafr_pkg::KIND_RMT: b = {hafr_pkg::TYPE_RMT, r.frame_id, 8'h00, 8'h00, 8'h00, 8'h00};
      default: b = {hafr_pkg::TYPE_LOC, r.frame_id};
    endcase
    if (r.kind != hafr_pkg::KIND_LOC) b = {b, r.ip[31:24], r.ip[23:16], r.ip[15:8], r.ip[7:0]};
    if (r.kind == hafr_pkg::KIND_RX) b = {b, r.margin, r.options};
    else b = {b, r.cmd[15:8], r.cmd[7:0], st};
    b = {b, pl};
    n = 16'(b.size());
    exp_q = {exp_q, hafr_pkg::DELIM, n[15:8], n[7:0]};
    foreach (b[k]) sum = sum + b[k];
    exp_q = {exp_q, b, 8'hFF - sum};
    if (feed) pay_q = {pay_q, pl};
    send_req(r);
  endtask

  task automatic drain(input int ex);
    int i;
    for (i = 0; i < 5000 && HOST.got_q.size() < exp_q.size(); i++) @(negedge ref_clk_i);
    if (i == 5000) hang();
    repeat (6) @(negedge ref_clk_i);
    `CHK(HOST.got_q.size(), exp_q.size())
    foreach (exp_q[k]) `CHK(HOST.got_q[k], exp_q[k])
    if (ex >= 0) `CHK(HOST.got_q[$], ex[7:0])
    HOST.got_q.delete();
    exp_q.delete();
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_local();
    logic [7:0] none[$];
    none = {};
    frame(mk(hafr_pkg::KIND_LOC, 8'h01, 16'h4244, 8'h00, 1'b0, 11'h000), none);
    drain(32'h0F0);
    // Statuses back to back; 4 is out of range; write carries no value
    for (int s = 1; s <= 4; s++) begin
      frame(mk(hafr_pkg::KIND_LOC, 8'(s), 16'h4244, 8'(s), 1'b0, 11'h003), none);
    end
    drain(-1);
    // Scan style answer: several read frames in a row
    frame(mk(hafr_pkg::KIND_LOC, 8'h7F, 16'h4153, 8'h00, 1'b1, 11'h002), {8'h25, 8'h80});
    frame(mk(hafr_pkg::KIND_LOC, 8'h7F, 16'h4153, 8'h00, 1'b1, 11'h001), {8'hC3});
    drain(-1);
  endtask

  task automatic s_remote();
    logic [7:0] none[$];
    none = {};
    frame(mk(hafr_pkg::KIND_RMT, 8'h01, 16'h4431, 8'h00, 1'b0, 11'h000), none);
    drain(32'h033);
    for (int s = 1; s <= 5; s++) begin
      frame(mk(hafr_pkg::KIND_RMT, 8'(s), 16'h4431, 8'(s), 1'b0, 11'h7F0), none);
    end
    frame(mk(hafr_pkg::KIND_RMT, 8'hA5, 16'h4944, 8'h00, 1'b1, 11'h001), {8'h5A});
    drain(-1);
  endtask

  task automatic s_rx();
    logic [7:0] pl[$];
    // Nonzero identifier must not leak into the address bytes
    frame(mk(hafr_pkg::KIND_RX, 8'h33, 16'h0000, 8'h00, 1'b0, 11'h005),
          {8'h48, 8'h65, 8'h6C, 8'h6C, 8'h6F});
    drain(32'h08E);
    // Fill the buffer before the frame starts, then drain into a slow host
    pl = {};
    for (int i = 0; i < 10; i++) pl.push_back(8'hA0 + 8'(i));
    stall = 1'b1;
    pay_q = pl;
    repeat (16) @(negedge ref_clk_i);
    `CHK(pay_ready_o, 1'b0)
    `CHK(pay_q.size(), 2)
    frame(mk(hafr_pkg::KIND_RX, 8'h00, 16'h0000, 8'h00, 1'b0, 11'h00A), pl, 1'b0);
    drain(-1);
    stall = 1'b0;
    // One byte over the limit: only 1392 bytes belong to the frame
    pl = {};
    for (int i = 0; i < 1392; i++) pl.push_back(8'(i));
    frame(mk(hafr_pkg::KIND_RX, 8'h00, 16'h0000, 8'h00, 1'b0, 11'h571), pl);
    drain(-1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk_i);
    `CHK(tx_valid_o, 1'b0)
    `CHK(req_ready_o, 1'b0)
    reset_n_i = 1'b1;
    s_local();
    s_remote();
    s_rx();
    stop_test();
  end
endmodule
